// File: core/xfer_pkg.sv
// Constants and types shared by the data-transfer execution unit and its element store.
// Assumes one clock domain and a flat element space of word-wide cells.
package xfer_pkg;
	// Element space: data cells below the counter region, counters above it
	localparam int WORD_W = 16;
	localparam int ADDR_W = 9;
	localparam int ELEM_COUNT = 512;
	localparam logic [8:0] DATA_LAST = 9'h0ff;
	localparam logic [7:0] CTR_DWORD_FIRST = 8'hc8;
	localparam logic [16:0] STACK_LIMIT = 17'h000ff;
	// Step counts of the fixed-length operations
	localparam logic [16:0] STEPS_ONE = 17'h00001;
	localparam logic [16:0] STEPS_PAIR = 17'h00002;
	localparam logic [16:0] STEPS_QUAD = 17'h00004;
	// Reset values
	localparam logic CARRY_RST = 1'b0;
	localparam logic [31:0] VALUE_RST = 32'h00000000;

	typedef enum logic [3:0] {
		NOP_OP = 4'h0,
		COPY_WORD_OP = 4'h1,
		COPY_DWORD_OP = 4'h2,
		COPY_REAL_OP = 4'h3,
		BLOCK_COPY_OP = 4'h4,
		BLOCK_FILL_OP = 4'h5,
		BLOCK_FILL_DWORD_OP = 4'h6,
		BYTE_SWAP_OP = 4'h7,
		WORD_TRADE_OP = 4'h8,
		DWORD_TRADE_OP = 4'h9,
		PUSH_OP = 4'ha
	} op_type;

	// Gray codes along idle, run, finish
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_FIN = 2'b11
	} state_type;
endpackage

// File: core/elem_if.sv
// Connection between the execution unit and its element store.
// Two double-word read ports, one word write port and one peek port.
`timescale 1ns/100ps
`default_nettype none
interface elem_if;
	logic [8:0] rd_a_addr;
	logic [31:0] rd_a_data;
	logic [8:0] rd_b_addr;
	logic [31:0] rd_b_data;
	logic wr_en;
	logic [8:0] wr_addr;
	logic [15:0] wr_data;
	logic [8:0] pk_addr;
	logic [15:0] pk_data;

	modport exec (
		output rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data, pk_addr,
		input rd_a_data, rd_b_data, pk_data
	);
	modport store (
		input rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data, pk_addr,
		output rd_a_data, rd_b_data, pk_data
	);
endinterface
`default_nettype wire

// File: core/elem_store.sv
// Element store: word cells in flip-flops, asynchronous reads, one synchronous write.
// Assumes the owner serialises all writes onto the single write port.
`timescale 1ns/100ps
`default_nettype none
module elem_store (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Store side of the carrier
	elem_if.store m
);
	logic [15:0] cell_r [xfer_pkg::ELEM_COUNT];
	logic [8:0] a_hi;
	logic [8:0] b_hi;

	// Upper word of a pair wraps around the element space
	assign a_hi = m.rd_a_addr + 9'h001;
	assign b_hi = m.rd_b_addr + 9'h001;
	assign m.rd_a_data = {cell_r[a_hi], cell_r[m.rd_a_addr]};
	assign m.rd_b_data = {cell_r[b_hi], cell_r[m.rd_b_addr]};
	assign m.pk_data = cell_r[m.pk_addr];

	// One process per cell keeps the write decode plain
	genvar g;
	generate
		for (g = 0; g < xfer_pkg::ELEM_COUNT; g++) begin : cells
			always_ff @(posedge i_clk) begin
				if (i_rst)
					cell_r[g] <= 16'h0000;
				else if (m.wr_en && m.wr_addr == 9'(g))
					cell_r[g] <= m.wr_data;
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: core/xfer_exec.sv
// Execution unit for data-transfer instructions over a flip-flop element store.
// Assumes the sequencer holds operands stable in the cycle it raises I_START.
// Function
// RL1: Word copy writes source into destination, source stays untouched.
// RL2: Element-to-element copy is signed; constant source keeps its own signedness.
// RL3: Program keeps word copy counter operands within counters 0 to 199.
// RL4: Double-word copy moves a word pair; counters limited to 200 to 255.
// RL5: Real copy moves the two-word value unchanged into the destination pair.
// RL6: Block copy moves size elements from source start, source unchanged.
// RL7: Word fill writes one source value into size destination elements.
// RL8: Program keeps fill counters within 0 to 199 and size non-negative.
// RL9: Double-word fill replicates the pair into size pairs, twice as many words.
// RL10: Program keeps double-word fill counters within 200 to 255, size non-negative.
// RL11: Program gives equal group counts when both operands use bit groups.
// RL12: Byte swap exchanges high and low bytes of the destination in place.
// RL13: Word trade swaps the contents of the two destination elements.
// RL14: Double-word trade swaps the contents of the two element pairs.
// RL15: Push increments the bottom count, then stores at bottom plus new count.
// RL16: Push onto a full stack stores nothing and sets the carry flag.
// RL17: Bad size, negative count or stack beyond range reports a stack error.
// RL18: Stack size excludes the bottom element and must exceed zero.
// RL19: Without power flow nothing is written and flags are left alone.
`timescale 1ns/100ps
`default_nettype none
module xfer_exec (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// Instruction issue
	input wire logic I_START,
	input wire logic I_POWER,
	input wire logic [3:0] I_OP,
	input wire logic [8:0] I_SRC,
	input wire logic [8:0] I_DST,
	input wire logic [15:0] I_SIZE,
	input wire logic I_SRC_CONST,
	input wire logic I_CONST_SIGNED,
	input wire logic [31:0] I_CONST,
	input wire logic [3:0] I_SRC_GRP,
	input wire logic [3:0] I_DST_GRP,
	// Flag handling
	input wire logic I_CARRY_CLR,
	// Element load and peek
	input wire logic I_LOAD_WE,
	input wire logic [8:0] I_LOAD_ADDR,
	input wire logic [15:0] I_LOAD_DATA,
	input wire logic [8:0] I_PEEK_ADDR,
	output logic [15:0] O_PEEK_DATA,
	// Status
	output logic O_BUSY,
	output logic O_DONE,
	output logic O_CARRY_FLAG,
	output logic O_ERR_STACK,
	output logic O_ERR_OPERAND,
	output logic O_SIGNED
);
	elem_if m ();

	elem_store store_u (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.m(m.store)
	);

	xfer_pkg::state_type state_r, state_nxt;
	xfer_pkg::op_type op_r, op_in;
	logic [8:0] s_r, d_r;
	logic [31:0] srcv_r, dstv_r;
	logic [16:0] steps_r, k_r, steps_in;
	logic desc_r;
	logic carry_r, err_stack_r, err_op_r, signed_r;
	logic [15:0] peek_r;

	// Counter ranges per operation width; real and stack operands take no counters
	function automatic logic ctr_bad(input xfer_pkg::op_type op, input logic [8:0] a);
		logic dw;
		dw = op == xfer_pkg::COPY_DWORD_OP || op == xfer_pkg::BLOCK_FILL_DWORD_OP
			|| op == xfer_pkg::DWORD_TRADE_OP;
		if (!a[8])
			ctr_bad = 1'b0;
		else if (op == xfer_pkg::COPY_REAL_OP || op == xfer_pkg::PUSH_OP)
			ctr_bad = 1'b1;
		else if (dw)
			ctr_bad = a[7:0] < xfer_pkg::CTR_DWORD_FIRST;
		else
			ctr_bad = a[7:0] >= xfer_pkg::CTR_DWORD_FIRST;
	endfunction

	// Operand decode at issue
	logic idle, accept, src_mem, grp_op, blk_op, op_err;
	logic [31:0] src_val;
	logic signed [15:0] cnt_in, size_in;
	logic [16:0] stack_end, size_abs;
	logic stack_err, stack_full, go;

	assign op_in = xfer_pkg::op_type'(I_OP);
	assign idle = state_r == xfer_pkg::ST_IDLE;
	assign accept = idle && I_START;
	assign src_mem = !I_SRC_CONST && op_in != xfer_pkg::BYTE_SWAP_OP;
	assign grp_op = op_in == xfer_pkg::BLOCK_FILL_OP || op_in == xfer_pkg::BLOCK_FILL_DWORD_OP
		|| op_in == xfer_pkg::WORD_TRADE_OP || op_in == xfer_pkg::DWORD_TRADE_OP;
	assign blk_op = op_in == xfer_pkg::BLOCK_COPY_OP || op_in == xfer_pkg::BLOCK_FILL_OP
		|| op_in == xfer_pkg::BLOCK_FILL_DWORD_OP;
	// Refusing bad operands here keeps a stray program from corrupting counters
	assign op_err = op_in == xfer_pkg::NOP_OP || ctr_bad(op_in, I_DST) // RL4
		|| (src_mem && ctr_bad(op_in, I_SRC))
		|| (grp_op && I_SRC_GRP != 4'h0 && I_DST_GRP != 4'h0 && I_SRC_GRP != I_DST_GRP)
		|| (blk_op && I_SIZE[15]);
	assign src_val = I_SRC_CONST ? I_CONST : m.rd_b_data;
	assign cnt_in = $signed(m.rd_a_data[15:0]);
	assign size_in = $signed(I_SIZE);
	assign size_abs = {1'b0, I_SIZE};
	// Top cell of the stack is bottom plus size; the bottom itself is not counted
	assign stack_end = {8'h00, I_DST} + size_abs; // RL18
	assign stack_err = op_in == xfer_pkg::PUSH_OP
		&& (size_in <= 16'sh0000 || cnt_in < 16'sh0000 || I_DST[8]
		|| stack_end > xfer_pkg::STACK_LIMIT); // RL17 RL18
	assign stack_full = op_in == xfer_pkg::PUSH_OP && !stack_err && cnt_in >= size_in; // RL16
	assign go = accept && I_POWER && !op_err && !stack_err && !stack_full; // RL19

	// Number of write cycles; each cycle writes exactly one word
	always_comb begin
		case (op_in)
			xfer_pkg::COPY_WORD_OP, xfer_pkg::BYTE_SWAP_OP: steps_in = xfer_pkg::STEPS_ONE;
			xfer_pkg::COPY_DWORD_OP, xfer_pkg::COPY_REAL_OP: steps_in = xfer_pkg::STEPS_PAIR;
			xfer_pkg::WORD_TRADE_OP, xfer_pkg::PUSH_OP: steps_in = xfer_pkg::STEPS_PAIR;
			xfer_pkg::DWORD_TRADE_OP: steps_in = xfer_pkg::STEPS_QUAD;
			xfer_pkg::BLOCK_COPY_OP, xfer_pkg::BLOCK_FILL_OP: steps_in = size_abs;
			xfer_pkg::BLOCK_FILL_DWORD_OP: steps_in = {I_SIZE, 1'b0}; // RL9
			default: steps_in = 17'h00000;
		endcase
	end

	// Sequencer
	logic last;
	assign last = k_r == steps_r - 17'h00001;
	always_comb begin
		case (state_r)
			xfer_pkg::ST_IDLE:
				state_nxt = !I_START ? xfer_pkg::ST_IDLE
					: (go && steps_in != 17'h00000) ? xfer_pkg::ST_RUN : xfer_pkg::ST_FIN;
			xfer_pkg::ST_RUN: state_nxt = last ? xfer_pkg::ST_FIN : xfer_pkg::ST_RUN;
			xfer_pkg::ST_FIN: state_nxt = xfer_pkg::ST_IDLE;
			default: state_nxt = xfer_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST)
			state_r <= xfer_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Operand capture; both sides are latched whole so trades need no extra reads
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			op_r <= xfer_pkg::NOP_OP;
			s_r <= 9'h000;
			d_r <= 9'h000;
			srcv_r <= xfer_pkg::VALUE_RST;
			dstv_r <= xfer_pkg::VALUE_RST;
			steps_r <= 17'h00000;
			desc_r <= 1'b0;
		end else if (go) begin
			op_r <= op_in;
			s_r <= I_SRC;
			d_r <= I_DST;
			srcv_r <= src_val;
			dstv_r <= m.rd_a_data;
			steps_r <= steps_in;
			desc_r <= I_DST > I_SRC;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST)
			k_r <= 17'h00000;
		else
			k_r <= (state_r == xfer_pkg::ST_RUN) ? k_r + 17'h00001 : 17'h00000;
	end

	// Block copy walks downward when the target lies above, so overlap reads old data
	logic [8:0] bidx, kidx, push_addr;
	assign kidx = k_r[8:0];
	assign bidx = desc_r ? 9'(steps_r - 17'h00001 - k_r) : kidx;
	assign push_addr = d_r + dstv_r[8:0] + 9'h001;
	assign m.rd_a_addr = I_DST;
	assign m.rd_b_addr = (state_r == xfer_pkg::ST_RUN) ? s_r + bidx : I_SRC; // RL6
	assign m.pk_addr = I_PEEK_ADDR;

	// Write selection per operation and step
	logic [8:0] x_addr;
	logic [15:0] x_data;
	always_comb begin
		x_addr = d_r;
		x_data = srcv_r[15:0];
		case (op_r)
			xfer_pkg::COPY_WORD_OP: x_data = srcv_r[15:0]; // RL1 RL2
			xfer_pkg::COPY_DWORD_OP, xfer_pkg::COPY_REAL_OP, xfer_pkg::BLOCK_FILL_DWORD_OP: begin
				x_addr = d_r + kidx; // RL4 RL5 RL9
				x_data = k_r[0] ? srcv_r[31:16] : srcv_r[15:0];
			end
			xfer_pkg::BLOCK_COPY_OP: begin
				x_addr = d_r + bidx; // RL6
				x_data = m.rd_b_data[15:0];
			end
			xfer_pkg::BLOCK_FILL_OP: x_addr = d_r + kidx; // RL7
			xfer_pkg::BYTE_SWAP_OP: x_data = {dstv_r[7:0], dstv_r[15:8]}; // RL12
			xfer_pkg::WORD_TRADE_OP: begin
				x_addr = k_r[0] ? s_r : d_r; // RL13
				x_data = k_r[0] ? dstv_r[15:0] : srcv_r[15:0];
			end
			xfer_pkg::DWORD_TRADE_OP: begin
				x_addr = (k_r[1] ? s_r : d_r) + {8'h00, k_r[0]}; // RL14
				case (k_r[1:0])
					2'b00: x_data = srcv_r[15:0];
					2'b01: x_data = srcv_r[31:16];
					2'b10: x_data = dstv_r[15:0];
					default: x_data = dstv_r[31:16];
				endcase
			end
			xfer_pkg::PUSH_OP: begin
				x_addr = k_r[0] ? push_addr : d_r; // RL15
				x_data = k_r[0] ? srcv_r[15:0] : dstv_r[15:0] + 16'h0001;
			end
			default: x_addr = d_r;
		endcase
	end

	// Loads from outside are only taken while idle so they never split an instruction
	assign m.wr_en = (state_r == xfer_pkg::ST_RUN) || (idle && I_LOAD_WE);
	assign m.wr_addr = (state_r == xfer_pkg::ST_RUN) ? x_addr : I_LOAD_ADDR;
	assign m.wr_data = (state_r == xfer_pkg::ST_RUN) ? x_data : I_LOAD_DATA;

	// Flags: power flow off leaves every flag as it was
	always_ff @(posedge I_CLK) begin
		if (I_RST)
			carry_r <= xfer_pkg::CARRY_RST;
		else if (accept && I_POWER && stack_full)
			carry_r <= 1'b1; // RL16
		else if (I_CARRY_CLR)
			carry_r <= 1'b0;
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			err_stack_r <= 1'b0;
			err_op_r <= 1'b0;
		end else if (accept && I_POWER) begin
			err_stack_r <= stack_err; // RL17
			err_op_r <= op_err;
		end
	end

	// Word and double-word copies from elements are signed; a constant keeps its own kind
	always_ff @(posedge I_CLK) begin
		if (I_RST)
			signed_r <= 1'b0;
		else if (go && (op_in == xfer_pkg::COPY_WORD_OP || op_in == xfer_pkg::COPY_DWORD_OP))
			signed_r <= !I_SRC_CONST || I_CONST_SIGNED; // RL2
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST)
			peek_r <= 16'h0000;
		else
			peek_r <= m.pk_data;
	end

	assign O_PEEK_DATA = peek_r;
	assign O_BUSY = !idle;
	assign O_DONE = state_r == xfer_pkg::ST_FIN;
	assign O_CARRY_FLAG = carry_r;
	assign O_ERR_STACK = err_stack_r;
	assign O_ERR_OPERAND = err_op_r;
	assign O_SIGNED = signed_r;
endmodule
`default_nettype wire

// File: tb/xfer_exec_sva.sv
// Checker for issue, completion and status timing of the transfer unit.
// Assumes one clock and a synchronous active-high reset; bound below.
`timescale 1ns/100ps
`default_nettype none
module xfer_exec_sva (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// Issue
	input wire logic I_START,
	input wire logic I_POWER,
	input wire logic [3:0] I_OP,
	input wire logic [8:0] I_SRC,
	input wire logic [8:0] I_DST,
	input wire logic [15:0] I_SIZE,
	input wire logic I_SRC_CONST,
	input wire logic [3:0] I_SRC_GRP,
	input wire logic [3:0] I_DST_GRP,
	// Status
	input wire logic O_BUSY,
	input wire logic O_DONE,
	input wire logic O_CARRY_FLAG,
	input wire logic O_ERR_STACK,
	input wire logic O_ERR_OPERAND,
	input wire logic O_SIGNED
);
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	// Accepted issue; plain operands avoid counters and bit groups
	wire acc = I_START && !O_BUSY && !I_RST;
	wire plain = !I_SRC[8] && !I_DST[8] && I_SRC_GRP == 4'h0 && I_DST_GRP == 4'h0;

	nopow_quiet_a: assert property (acc && !I_POWER |=> O_DONE &&
		$stable({O_ERR_STACK, O_ERR_OPERAND, O_SIGNED})) else $error("flags moved without power");
	word_time_a: assert property (acc && I_POWER && plain && I_OP == 4'h1
		|=> !O_DONE ##1 O_DONE) else $error("word copy end misplaced");
	trade_time_a: assert property (acc && I_POWER && plain && I_OP == 4'h9
		|=> !O_DONE [*4] ##1 O_DONE) else $error("double trade end misplaced");
	block_time_a: assert property (acc && I_POWER && plain && I_OP == 4'h4
		&& I_SIZE == 16'h0003 |=> O_BUSY [*3] ##1 O_DONE) else $error("block copy end misplaced");
	carry_run_a: assert property ($rose(O_CARRY_FLAG) |-> O_BUSY || $past(O_BUSY))
		else $error("carry rose while idle");
	stack_err_a: assert property (acc && I_POWER && I_OP == 4'ha
		&& $signed(I_SIZE) <= 0 |-> ##[1:2] O_ERR_STACK) else $error("stack error missing");
	fill_neg_a: assert property (acc && I_POWER && I_OP == 4'h5 && I_SIZE[15]
		|=> O_DONE ##[0:1] O_ERR_OPERAND) else $error("negative fill accepted");
	signed_copy_a: assert property (acc && I_POWER && plain && !I_SRC_CONST
		&& I_OP == 4'h1 |-> ##[1:2] O_SIGNED) else $error("element copy not signed");
endmodule
bind xfer_exec xfer_exec_sva xfer_exec_sva_i (
	.I_CLK(I_CLK),
	.I_RST(I_RST),
	.I_START(I_START),
	.I_POWER(I_POWER),
	.I_OP(I_OP),
	.I_SRC(I_SRC),
	.I_DST(I_DST),
	.I_SIZE(I_SIZE),
	.I_SRC_CONST(I_SRC_CONST),
	.I_SRC_GRP(I_SRC_GRP),
	.I_DST_GRP(I_DST_GRP),
	.O_BUSY(O_BUSY),
	.O_DONE(O_DONE),
	.O_CARRY_FLAG(O_CARRY_FLAG),
	.O_ERR_STACK(O_ERR_STACK),
	.O_ERR_OPERAND(O_ERR_OPERAND),
	.O_SIGNED(O_SIGNED)
);
`default_nettype wire

// File: tb/xfer_seq.sv
// Instruction issuer standing in for the program sequencer.
// Assumes every issue ends in a done pulse; the bench watchdog bounds a hang.
`timescale 1ns/100ps
`default_nettype none
module xfer_seq (
	// Clock and status
	input wire logic i_clk,
	input wire logic i_busy,
	input wire logic i_done,
	// Issue fields
	output logic o_start,
	output logic o_power,
	output logic [3:0] o_op,
	output logic [8:0] o_src,
	output logic [8:0] o_dst,
	output logic [15:0] o_size,
	output logic o_cst,
	output logic o_csg,
	output logic [31:0] o_k
);
	// Quiet fields until the first issue
	initial begin
		{o_start, o_power, o_op, o_src, o_dst, o_size, o_cst, o_csg, o_k} = '0;
	end
	// One issue: strobe a single cycle while idle, then await done; a hang reaches the watchdog
	task automatic issue(input logic [3:0] op, input logic [8:0] s, input logic [8:0] d,
		input logic [15:0] n, input logic [2:0] c, input logic [31:0] k = 32'h0);
		while (i_busy)
			@(posedge i_clk) #1;
		{o_power, o_cst, o_csg} = c;
		o_op = op;
		o_src = s; // Operands passed through as given; no counter range check here
		o_dst = d;
		o_size = n;
		o_k = k;
		o_start = 1'b1;
		@(posedge i_clk) #1;
		o_start = 1'b0;
		while (!i_done)
			@(posedge i_clk) #1;
		@(posedge i_clk) #1;
	endtask
endmodule
`default_nettype wire

// File: tb/xfer_exec_tb.sv
// Bench for the transfer unit: loads cells, issues through the model, peeks results.
// Assumes the issuer model drives the issue fields; checker is bound to the unit.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module xfer_exec_tb;
	logic I_CLK = 1'b0;
	logic I_RST = 1'b1;
	logic I_START, I_POWER, I_SRC_CONST, I_CONST_SIGNED, O_BUSY, O_DONE;
	logic I_CARRY_CLR = 1'b0;
	logic I_LOAD_WE = 1'b0;
	logic O_CARRY_FLAG, O_ERR_STACK, O_ERR_OPERAND, O_SIGNED;
	logic [3:0] I_OP;
	logic [3:0] I_SRC_GRP = 4'h0; // Equal group counts
	logic [3:0] I_DST_GRP = 4'h0;
	logic [8:0] I_SRC, I_DST, I_LOAD_ADDR = 9'h000, I_PEEK_ADDR = 9'h000;
	logic [15:0] I_SIZE, I_LOAD_DATA = 16'h0000, O_PEEK_DATA, a, b, e, k;
	logic [31:0] I_CONST;
	logic [15:0] v[3];
	logic [19:0] exp_q[$];
	logic [19:0] nx;
	logic [3:0] ef = 4'h0;
	logic pk_v = 1'b0;
	logic pk_d = 1'b0;
	int n_fail = 0;
	int checks = 0;

	always #2 I_CLK = ~I_CLK;
	xfer_exec xfer_exec_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_START(I_START), .I_POWER(I_POWER),
		.I_OP(I_OP), .I_SRC(I_SRC), .I_DST(I_DST), .I_SIZE(I_SIZE), .I_SRC_CONST(I_SRC_CONST),
		.I_CONST_SIGNED(I_CONST_SIGNED), .I_CONST(I_CONST), .I_SRC_GRP(I_SRC_GRP),
		.I_DST_GRP(I_DST_GRP), .I_CARRY_CLR(I_CARRY_CLR), .I_LOAD_WE(I_LOAD_WE),
		.I_LOAD_ADDR(I_LOAD_ADDR), .I_LOAD_DATA(I_LOAD_DATA), .I_PEEK_ADDR(I_PEEK_ADDR),
		.O_PEEK_DATA(O_PEEK_DATA), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
		.O_CARRY_FLAG(O_CARRY_FLAG), .O_ERR_STACK(O_ERR_STACK),
		.O_ERR_OPERAND(O_ERR_OPERAND), .O_SIGNED(O_SIGNED));
	xfer_seq xfer_seq_i (.i_clk(I_CLK), .i_busy(O_BUSY), .i_done(O_DONE), .o_start(I_START),
		.o_power(I_POWER), .o_op(I_OP), .o_src(I_SRC), .o_dst(I_DST), .o_size(I_SIZE),
		.o_cst(I_SRC_CONST), .o_csg(I_CONST_SIGNED), .o_k(I_CONST));

	// Flags ride along with every peek, so a stray flag change shows anywhere
	always @(posedge I_CLK) pk_d <= pk_v;
	always @(negedge I_CLK) begin
		if (pk_d) begin
			nx = exp_q.pop_front();
			`CHK({O_CARRY_FLAG, O_ERR_STACK, O_ERR_OPERAND, O_SIGNED, O_PEEK_DATA}, nx)
		end
	end

	task automatic ld(input logic [8:0] ad, input logic [15:0] d);
		I_LOAD_ADDR = ad;
		I_LOAD_DATA = d;
		I_LOAD_WE = 1'b1;
		@(posedge I_CLK) #1;
	endtask
	task automatic pk(input logic [8:0] ad, input logic [15:0] d);
		I_PEEK_ADDR = ad;
		exp_q.push_back({ef, d});
		pk_v = 1'b1;
		@(posedge I_CLK) #1;
		pk_v = 1'b0;
		@(posedge I_CLK) #1;
	endtask
	task automatic print_verdict;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Whole run is well under a thousand cycles; this allows several times that
	initial begin
		#20000;
		n_fail++;
		print_verdict();
	end

	initial begin
		void'($urandom(32'h9e835f02));
		a = 16'($urandom());
		b = 16'($urandom());
		e = 16'($urandom());
		k = 16'($urandom());
		v = '{a, b, e};
		repeat (12) @(posedge I_CLK);
		#1 I_RST = 1'b0;
		for (int i = 0; i < 3; i++)
			ld(9'h002 + 9'(i), v[i]);
		ld(9'h064, 16'h0008);
		I_LOAD_WE = 1'b0;
		xfer_seq_i.issue(4'h1, 9'h002, 9'h005, 16'h0, 3'b100);
		ef = 4'h1;
		pk(9'h005, a);
		pk(9'h002, a);
		xfer_seq_i.issue(4'h1, 9'h000, 9'h006, 16'h0, 3'b110, {16'h0, k});
		ef = 4'h0;
		pk(9'h006, k);
		xfer_seq_i.issue(4'h1, 9'h000, 9'h008, 16'h0, 3'b111, {16'h0, b});
		ef = 4'h1;
		pk(9'h008, b);
		xfer_seq_i.issue(4'h2, 9'h002, 9'h00a, 16'h0, 3'b100);
		ef = 4'h1;
		pk(9'h00b, b);
		xfer_seq_i.issue(4'h3, 9'h00a, 9'h00c, 16'h0, 3'b100);
		pk(9'h00c, a);
		pk(9'h00d, b);
		xfer_seq_i.issue(4'h1, 9'h002, 9'h1c8, 16'h0, 3'b100);
		ef = 4'h3;
		pk(9'h1c8, 16'h0);
		xfer_seq_i.issue(4'h2, 9'h002, 9'h1c8, 16'h0, 3'b100);
		ef = 4'h1;
		pk(9'h1c9, b);
		$display("test single copies over");
		xfer_seq_i.issue(4'h4, 9'h002, 9'h01e, 16'h3, 3'b100);
		xfer_seq_i.issue(4'h5, 9'h004, 9'h028, 16'h3, 3'b100);
		xfer_seq_i.issue(4'h6, 9'h002, 9'h032, 16'h2, 3'b100);
		for (int i = 0; i < 4; i++) begin
			pk(9'h01e + 9'(i), (i < 3) ? v[i] : 16'h0);
			pk(9'h028 + 9'(i), (i < 3) ? e : 16'h0);
			pk(9'h032 + 9'(i), v[i % 2]);
		end
		pk(9'h036, 16'h0);
		xfer_seq_i.issue(4'h5, 9'h004, 9'h03c, 16'hffff, 3'b100);
		ef = 4'h3;
		pk(9'h03c, 16'h0);
		$display("test blocks over");
		xfer_seq_i.issue(4'h7, 9'h000, 9'h002, 16'h0, 3'b100);
		ef = 4'h1;
		pk(9'h002, {a[7:0], a[15:8]});
		xfer_seq_i.issue(4'h8, 9'h003, 9'h005, 16'h0, 3'b100);
		pk(9'h003, a);
		pk(9'h005, b);
		I_SRC_GRP = 4'h2;
		I_DST_GRP = 4'h3;
		xfer_seq_i.issue(4'h5, 9'h004, 9'h03d, 16'h1, 3'b100);
		ef = 4'h3;
		pk(9'h03d, 16'h0);
		I_DST_GRP = 4'h2;
		xfer_seq_i.issue(4'h5, 9'h004, 9'h03d, 16'h1, 3'b100);
		ef = 4'h1;
		pk(9'h03d, e);
		I_SRC_GRP = 4'h0;
		I_DST_GRP = 4'h0;
		xfer_seq_i.issue(4'h9, 9'h028, 9'h00c, 16'h0, 3'b100);
		for (int i = 0; i < 2; i++) begin
			pk(9'h00c + 9'(i), e);
			pk(9'h028 + 9'(i), v[i]);
		end
		$display("test swaps over");
		repeat (3) xfer_seq_i.issue(4'ha, 9'h004, 9'h064, 16'd10, 3'b100);
		ef = 4'h9;
		pk(9'h064, 16'd10);
		pk(9'h06d, e);
		pk(9'h06e, e);
		pk(9'h06f, 16'h0);
		xfer_seq_i.issue(4'ha, 9'h004, 9'h064, 16'h0, 3'b100);
		ef = 4'hd;
		pk(9'h064, 16'd10);
		xfer_seq_i.issue(4'h1, 9'h002, 9'h007, 16'h0, 3'b000);
		pk(9'h007, 16'h0);
		I_CARRY_CLR = 1'b1;
		@(posedge I_CLK) #1;
		I_CARRY_CLR = 1'b0;
		ef = 4'h5;
		pk(9'h007, 16'h0);
		$display("test stack and power over");
		print_verdict();
	end
endmodule
`default_nettype wire
